// ==== core/agcts_cfg.svh ====
`ifndef AGCTS_CFG_SVH
`define AGCTS_CFG_SVH

// register indices; byte address is four times the index
`define AGCTS_IDX_LOOP_CFG 10'h01E
`define AGCTS_IDX_STATIC 10'h01F
`define AGCTS_IDX_TX_CTRL 10'h020
`define AGCTS_IDX_GAIN_STAT 10'h03F

// clock
`define AGCTS_CLK_PERIOD_NS 40

// gain_loop_config fields
`define AGCTS_VREF_HI 15
`define AGCTS_VREF_LO 14
`define AGCTS_PER_HI 13
`define AGCTS_PER_LO 4
`define AGCTS_SRC_BIT 3
`define AGCTS_LOAD_BIT 2
`define AGCTS_FIX_BIT 1
`define AGCTS_EN_BIT 0

// gain_static_values fields
`define AGCTS_RDR_HI 19
`define AGCTS_RDR_LO 10
`define AGCTS_CRD_HI 9
`define AGCTS_CRD_LO 0

// transmit_shaping_control fields
`define AGCTS_DRV_BIT 26
`define AGCTS_AMP_HI 25
`define AGCTS_AMP_LO 24
`define AGCTS_OVR_HI 23
`define AGCTS_OVR_LO 19
`define AGCTS_MAX_BIT 18
`define AGCTS_RES_HI 17
`define AGCTS_RES_LO 13
`define AGCTS_BYP_BIT 12
`define AGCTS_SLEW_HI 11
`define AGCTS_SLEW_LO 8
`define AGCTS_FALL_HI 7
`define AGCTS_FALL_LO 4
`define AGCTS_RISE_HI 3
`define AGCTS_RISE_LO 0

// gain status fields
`define AGCTS_STAT_LOOP_BIT 10
`define AGCTS_STAT_LEVEL_BIT 11

// reset and limit values
`define AGCTS_VREF_RST 2'h2
`define AGCTS_PER_RST 10'h200
`define AGCTS_SRC_RST 1'h0
`define AGCTS_FIX_RST 1'h1
`define AGCTS_EN_RST 1'h1
`define AGCTS_GAIN_RST 10'h000
`define AGCTS_GAIN_MAX 10'h3FF
`define AGCTS_AMP_MAX 2'h3
`define AGCTS_PER_MIN 10'h004

`endif

// ==== core/agcts_period_timer.sv ====
`timescale 1ns/1ps
module agcts_period_timer #(
  parameter int PER_W = 10
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic enable,
  input wire logic [PER_W-1:0] period,
  output logic tick
);
  logic [PER_W-1:0] cnt_ff;
  logic tick_ff;

  // one tick every period+1 cycles while enabled
  always_ff @(posedge clk_sys) begin
    if (reset || !enable) begin
      cnt_ff <= period;
      tick_ff <= 1'h0;
    end else if (cnt_ff == '0) begin
      cnt_ff <= period;
      tick_ff <= 1'h1;
    end else begin
      cnt_ff <= cnt_ff - 1'b1;
      tick_ff <= 1'h0;
    end
  end

  assign tick = tick_ff;
endmodule

// ==== core/agcts_pkg.sv ====
package agcts_pkg;
  typedef logic [9:0] agcts_gain_type;
  typedef enum logic [2:0] {
    SEL_LOOP_CFG = 3'b000,
    SEL_STATIC = 3'b001,
    SEL_TX_CTRL = 3'b010,
    SEL_GAIN_STAT = 3'b011,
    SEL_NONE = 3'b100
  } agcts_sel_type;
endpackage

// ==== core/agcts_regs.sv ====
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`include "agcts_cfg.svh"
module agcts_regs #(
  parameter int PADDR_W = 12
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_level_above_ref,
  input wire logic overshoot_active,
  input wire logic single_pump_mode,
  output logic [1:0] gain_reference_select,
  output logic [9:0] gain_value,
  output logic gain_loop_active,
  output logic load_mod_driver_select,
  output logic [1:0] card_carrier_amplitude,
  output logic card_carrier_force_max,
  output logic [4:0] residual_carrier,
  output logic [3:0] shunt_slew_rate,
  output logic shaping_bypass,
  output logic [3:0] fall_edge_tau,
  output logic [3:0] rise_edge_tau
);
  // gain_loop_config
  logic [1:0] vref_ff;
  logic [9:0] period_ff;
  logic src_sel_ff;
  logic fixed_src_ff;
  logic loop_en_ff;
  logic load_ff;
  // gain_static_values
  agcts_pkg::agcts_gain_type reader_gain_ff;
  agcts_pkg::agcts_gain_type card_gain_ff;
  // transmit_shaping_control
  logic drv_sel_ff;
  logic [1:0] amp_ff;
  logic [4:0] ovres_ff;
  logic force_max_ff;
  logic [4:0] res_ff;
  logic bypass_ff;
  logic [3:0] slew_ff;
  logic [3:0] fall_ff;
  logic [3:0] rise_ff;
  // divider and outputs
  agcts_pkg::agcts_gain_type gain_ff;
  logic level_meta_ff;
  logic level_sync_ff;
  logic [1:0] amp_out_ff;
  logic [4:0] res_out_ff;
  logic [3:0] fall_out_ff;
  logic [3:0] rise_out_ff;
  // bus
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [31:0] nxt_prdata;
  agcts_pkg::agcts_sel_type sel;
  logic setup;
  logic wr_cfg;
  logic wr_val;
  logic wr_tx;
  logic tick;
  agcts_pkg::agcts_gain_type static_sel;

  function automatic agcts_pkg::agcts_sel_type decode(input logic [PADDR_W-1:0] a);
    logic [PADDR_W-1:0] cfg_a;
    logic [PADDR_W-1:0] val_a;
    logic [PADDR_W-1:0] tx_a;
    logic [PADDR_W-1:0] st_a;
    cfg_a = PADDR_W'({`AGCTS_IDX_LOOP_CFG, 2'h0});
    val_a = PADDR_W'({`AGCTS_IDX_STATIC, 2'h0});
    tx_a = PADDR_W'({`AGCTS_IDX_TX_CTRL, 2'h0});
    st_a = PADDR_W'({`AGCTS_IDX_GAIN_STAT, 2'h0});
    if (a == cfg_a) begin
      decode = agcts_pkg::SEL_LOOP_CFG;
    end else if (a == val_a) begin
      decode = agcts_pkg::SEL_STATIC;
    end else if (a == tx_a) begin
      decode = agcts_pkg::SEL_TX_CTRL;
    end else if (a == st_a) begin
      decode = agcts_pkg::SEL_GAIN_STAT;
    end else begin
      decode = agcts_pkg::SEL_NONE;
    end
  endfunction

  assign sel = decode(paddr);
  assign setup = psel && !penable;
  assign wr_cfg = psel && penable && pready_ff && pwrite && (sel == agcts_pkg::SEL_LOOP_CFG);
  assign wr_val = psel && penable && pready_ff && pwrite && (sel == agcts_pkg::SEL_STATIC);
  assign wr_tx = psel && penable && pready_ff && pwrite && (sel == agcts_pkg::SEL_TX_CTRL);
  assign static_sel = src_sel_ff ? reader_gain_ff : card_gain_ff;

  // apb answer: one access cycle, no wait states
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready_ff <= 1'h0;
      pslverr_ff <= 1'h0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && (sel == agcts_pkg::SEL_NONE);
      prdata_ff <= setup && !pwrite ? nxt_prdata : 32'h0000_0000;
    end
  end

  // read mux; unlisted bits stay zero
  always_comb begin
    nxt_prdata = 32'h0000_0000;
    case (sel)
      agcts_pkg::SEL_LOOP_CFG: begin
        nxt_prdata[`AGCTS_VREF_HI:`AGCTS_VREF_LO] = vref_ff;
        nxt_prdata[`AGCTS_PER_HI:`AGCTS_PER_LO] = period_ff;
        nxt_prdata[`AGCTS_SRC_BIT] = src_sel_ff;
        nxt_prdata[`AGCTS_FIX_BIT] = fixed_src_ff;
        nxt_prdata[`AGCTS_EN_BIT] = loop_en_ff;
      end
      agcts_pkg::SEL_STATIC: begin
        nxt_prdata[`AGCTS_RDR_HI:`AGCTS_RDR_LO] = reader_gain_ff;
        nxt_prdata[`AGCTS_CRD_HI:`AGCTS_CRD_LO] = card_gain_ff;
      end
      agcts_pkg::SEL_TX_CTRL: begin
        nxt_prdata[`AGCTS_DRV_BIT] = drv_sel_ff;
        nxt_prdata[`AGCTS_AMP_HI:`AGCTS_AMP_LO] = amp_ff;
        nxt_prdata[`AGCTS_OVR_HI:`AGCTS_OVR_LO] = ovres_ff;
        nxt_prdata[`AGCTS_MAX_BIT] = force_max_ff;
        nxt_prdata[`AGCTS_RES_HI:`AGCTS_RES_LO] = res_ff;
        nxt_prdata[`AGCTS_BYP_BIT] = bypass_ff;
        nxt_prdata[`AGCTS_SLEW_HI:`AGCTS_SLEW_LO] = slew_ff;
        nxt_prdata[`AGCTS_FALL_HI:`AGCTS_FALL_LO] = fall_ff;
        nxt_prdata[`AGCTS_RISE_HI:`AGCTS_RISE_LO] = rise_ff;
      end
      agcts_pkg::SEL_GAIN_STAT: begin
        nxt_prdata[9:0] = gain_ff;
        nxt_prdata[`AGCTS_STAT_LOOP_BIT] = loop_en_ff;
        nxt_prdata[`AGCTS_STAT_LEVEL_BIT] = level_sync_ff;
      end
      default: begin
        nxt_prdata = 32'h0000_0000;
      end
    endcase
  end

  // loop configuration
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      vref_ff <= `AGCTS_VREF_RST;
      period_ff <= `AGCTS_PER_RST;
      src_sel_ff <= `AGCTS_SRC_RST;
      fixed_src_ff <= `AGCTS_FIX_RST;
      loop_en_ff <= `AGCTS_EN_RST;
    end else if (wr_cfg) begin
      vref_ff <= pwdata[`AGCTS_VREF_HI:`AGCTS_VREF_LO];
      period_ff <= pwdata[`AGCTS_PER_HI:`AGCTS_PER_LO];
      src_sel_ff <= pwdata[`AGCTS_SRC_BIT];
      fixed_src_ff <= pwdata[`AGCTS_FIX_BIT];
      loop_en_ff <= pwdata[`AGCTS_EN_BIT];
    end
  end

  // load strobe lives one cycle and clears itself
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      load_ff <= 1'h0;
    end else begin
      load_ff <= wr_cfg && pwdata[`AGCTS_LOAD_BIT];
    end
  end

  // static gains
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reader_gain_ff <= `AGCTS_GAIN_RST;
      card_gain_ff <= `AGCTS_GAIN_RST;
    end else if (wr_val) begin
      reader_gain_ff <= pwdata[`AGCTS_RDR_HI:`AGCTS_RDR_LO];
      card_gain_ff <= pwdata[`AGCTS_CRD_HI:`AGCTS_CRD_LO];
    end
  end

  // transmit shaping
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      drv_sel_ff <= 1'h0;
      amp_ff <= 2'h0;
      ovres_ff <= 5'h00;
      force_max_ff <= 1'h0;
      res_ff <= 5'h00;
      bypass_ff <= 1'h0;
      slew_ff <= 4'h0;
      fall_ff <= 4'h0;
      rise_ff <= 4'h0;
    end else if (wr_tx) begin
      drv_sel_ff <= pwdata[`AGCTS_DRV_BIT];
      amp_ff <= pwdata[`AGCTS_AMP_HI:`AGCTS_AMP_LO];
      ovres_ff <= pwdata[`AGCTS_OVR_HI:`AGCTS_OVR_LO];
      force_max_ff <= pwdata[`AGCTS_MAX_BIT];
      res_ff <= pwdata[`AGCTS_RES_HI:`AGCTS_RES_LO];
      bypass_ff <= pwdata[`AGCTS_BYP_BIT];
      slew_ff <= pwdata[`AGCTS_SLEW_HI:`AGCTS_SLEW_LO];
      fall_ff <= pwdata[`AGCTS_FALL_HI:`AGCTS_FALL_LO];
      rise_ff <= pwdata[`AGCTS_RISE_HI:`AGCTS_RISE_LO];
    end
  end

  // effective transmit settings
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      amp_out_ff <= 2'h0;
      res_out_ff <= 5'h00;
      fall_out_ff <= 4'h0;
      rise_out_ff <= 4'h0;
    end else begin
      amp_out_ff <= force_max_ff ? `AGCTS_AMP_MAX : amp_ff;
      res_out_ff <= overshoot_active ? ovres_ff : res_ff;
      fall_out_ff <= single_pump_mode ? fall_ff : 4'h0;
      rise_out_ff <= (single_pump_mode && !bypass_ff) ? rise_ff : 4'h0;
    end
  end

  // comparator pin synchroniser
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level_meta_ff <= 1'h0;
      level_sync_ff <= 1'h0;
    end else begin
      level_meta_ff <= rx_level_above_ref;
      level_sync_ff <= level_meta_ff;
    end
  end

  // update interval; period below 4 is not supported by software
  agcts_period_timer #(
    .PER_W(10)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(loop_en_ff),
    .period(period_ff),
    .tick(tick)
  );

  // receive divider: load wins, else closed-loop step, else frozen
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      gain_ff <= `AGCTS_GAIN_RST;
    end else if (load_ff) begin
      gain_ff <= static_sel;
    end else if (loop_en_ff && tick) begin
      if (level_sync_ff && gain_ff != `AGCTS_GAIN_MAX) begin
        gain_ff <= gain_ff + 10'h001;
      end else if (!level_sync_ff && gain_ff != `AGCTS_GAIN_RST) begin
        gain_ff <= gain_ff - 10'h001;
      end
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign gain_reference_select = vref_ff;
  assign gain_value = gain_ff;
  assign gain_loop_active = loop_en_ff;
  assign load_mod_driver_select = drv_sel_ff;
  assign card_carrier_amplitude = amp_out_ff;
  assign card_carrier_force_max = force_max_ff;
  assign residual_carrier = res_out_ff;
  assign shunt_slew_rate = slew_ff;
  assign shaping_bypass = bypass_ff;
  assign fall_edge_tau = fall_out_ff;
  assign rise_edge_tau = rise_out_ff;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  sequence cfg_write_load_s;
    wr_cfg && pwdata[`AGCTS_LOAD_BIT];
  endsequence

  sequence strobe_pulse_s;
    load_ff ##1 !load_ff;
  endsequence

  load_copy_a: assert property (load_ff |=> gain_ff == $past(static_sel))
    else $error("divider did not take chosen static gain");
  strobe_clear_a: assert property (cfg_write_load_s |=> strobe_pulse_s)
    else $error("load strobe did not pulse once");
  src_select_a: assert property (load_ff && src_sel_ff |=> gain_ff == $past(reader_gain_ff))
    else $error("reader static gain not used");
  fixed_hold_a: assert property (!loop_en_ff && !load_ff |=> $stable(gain_ff))
    else $error("divider moved in fixed operation");
  fix_no_load_a: assert property (wr_cfg && !pwdata[`AGCTS_LOAD_BIT] && !loop_en_ff
    |=> !load_ff ##1 $stable(gain_ff))
    else $error("config write loaded divider");
  tick_space_a: assert property (tick && period_ff >= `AGCTS_PER_MIN && $stable(period_ff)
    |=> !tick [*3])
    else $error("update ticks too close");
  loop_step_a: assert property (loop_en_ff && tick && !load_ff && level_sync_ff
    && gain_ff != `AGCTS_GAIN_MAX |=> gain_ff == $past(gain_ff) + 10'h001)
    else $error("closed loop did not raise gain");
  rise_gate_a: assert property (bypass_ff |=> rise_edge_tau == 4'h0)
    else $error("rising tau not ignored under bypass");
  pump_gate_a: assert property (!single_pump_mode |=> fall_edge_tau == 4'h0)
    else $error("falling tau active outside single pump");
  resid_sel_a: assert property (overshoot_active |=> residual_carrier == $past(ovres_ff))
    else $error("overshoot residual level not applied");
  carrier_max_a: assert property (force_max_ff |=> card_carrier_amplitude == 2'h3)
    else $error("carrier force max not applied");
  rsvd_read_a: assert property (setup && !pwrite && sel == agcts_pkg::SEL_LOOP_CFG
    |=> pready && prdata[31:16] == 16'h0000 && !prdata[`AGCTS_LOAD_BIT])
    else $error("reserved or strobe bits read nonzero");
endmodule

// ==== verif/agcts_rx_model.sv ====
`timescale 1ns/1ps
module agcts_rx_model #(
  parameter logic [9:0] TARGET = 10'h2B0
) (
  input wire logic clk_sys,
  input wire logic [9:0] gain_value,
  output logic rx_level_above_ref
);
  // comparator: level stays above target while too few resistors are added
  always_ff @(posedge clk_sys) begin
    rx_level_above_ref <= (gain_value < TARGET);
  end
endmodule

// ==== verif/agcts_tb.sv ====
`timescale 1ns/1ps
module testbench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic overshoot_active = 1'b0;
  logic single_pump_mode = 1'b1;
  logic [31:0] prdata;
  logic pready, pslverr, rx_level_above_ref, gain_loop_active;
  logic load_mod_driver_select, card_carrier_force_max, shaping_bypass;
  logic [1:0] gain_reference_select, card_carrier_amplitude;
  logic [9:0] gain_value;
  logic [4:0] residual_carrier;
  logic [3:0] shunt_slew_rate, fall_edge_tau, rise_edge_tau;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  always #20 clk_sys = ~clk_sys;

  agcts_regs DUT (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rx_level_above_ref, .overshoot_active,
    .single_pump_mode, .gain_reference_select, .gain_value, .gain_loop_active,
    .load_mod_driver_select, .card_carrier_amplitude, .card_carrier_force_max,
    .residual_carrier, .shunt_slew_rate, .shaping_bypass, .fall_edge_tau,
    .rise_edge_tau);

  agcts_rx_model #(.TARGET(10'h2B0)) rx_model (.clk_sys, .gain_value,
    .rx_level_above_ref);

  task automatic conclude;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      $display("ERROR %0t: run timed out", $time);
      conclude();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // apb transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cmp(32'(n), 32'h1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    cmp(q, exp);
    cmp(32'(e), 32'(eexp));
  endtask

  task automatic wait_chg(output int n);
    logic [9:0] v;
    v = gain_value;
    n = 0;
    while (gain_value === v && n < 50) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  task automatic t_reset;
    cmp(32'(gain_reference_select), 32'h2);
    cmp(32'(gain_loop_active), 32'h1);
    cmp(32'(gain_value), 32'h0);
    rd_chk(12'h078, 32'h0000A003, 1'b0);
    rd_chk(12'h07C, 32'h0, 1'b0);
    rd_chk(12'h080, 32'h0, 1'b0);
    $display("test reset done");
  endtask

  task automatic t_regs;
    wr(12'h07C, 32'hFFFFFFFF);
    rd_chk(12'h07C, 32'h000FFFFF, 1'b0);
    wr(12'h080, 32'hFFFFFFFF);
    rd_chk(12'h080, 32'h07FFFFFF, 1'b0);
    wr(12'h078, 32'hFFFFFFFF);
    rd_chk(12'h078, 32'h0000FFFB, 1'b0);
    cmp(32'(gain_reference_select), 32'h3);
    rd_chk(12'h100, 32'h0, 1'b1);
    $display("test registers done");
  endtask

  task automatic t_load;
    wr(12'h07C, 32'h000556AA);
    wr(12'h078, 32'h0000804E);
    waitc(3);
    cmp(32'(gain_value), 32'h155);
    rd_chk(12'h078, 32'h0000804A, 1'b0);
    wr(12'h078, 32'h00008046);
    waitc(3);
    cmp(32'(gain_value), 32'h2AA);
    wr(12'h078, 32'h00008048);
    waitc(5);
    cmp(32'(gain_value), 32'h2AA);
    rd_chk(12'h0FC, 32'h00000AAA, 1'b0);
    $display("test load done");
  endtask

  task automatic t_loop;
    int n;
    logic [9:0] v;
    wr(12'h078, 32'h00008041);
    wait_chg(n);
    v = gain_value;
    wait_chg(n);
    cmp(32'(n), 32'h5);
    cmp(32'(gain_value), 32'(v + 10'h001));
    waitc(100);
    cmp(32'(gain_value >= 10'h2AF && gain_value <= 10'h2B0), 32'h1);
    wr(12'h078, 32'h00008042);
    waitc(2);
    v = gain_value;
    waitc(30);
    cmp(32'(gain_value), 32'(v));
    rd_chk(12'h078, 32'h00008042, 1'b0);
    cmp(32'(gain_loop_active), 32'h0);
    $display("test loop done");
  endtask

  task automatic t_tx;
    wr(12'h080, 32'h0552AC59);
    waitc(2);
    cmp(32'(load_mod_driver_select), 32'h1);
    cmp(32'(card_carrier_amplitude), 32'h1);
    cmp(32'(residual_carrier), 32'h15);
    cmp(32'(shunt_slew_rate), 32'hC);
    cmp(32'(fall_edge_tau), 32'h5);
    cmp(32'(rise_edge_tau), 32'h9);
    overshoot_active <= 1'b1;
    single_pump_mode <= 1'b0;
    waitc(2);
    cmp(32'(residual_carrier), 32'hA);
    cmp(32'(fall_edge_tau), 32'h0);
    cmp(32'(rise_edge_tau), 32'h0);
    overshoot_active <= 1'b0;
    single_pump_mode <= 1'b1;
    wr(12'h080, 32'h0556BC59);
    waitc(2);
    cmp(32'(card_carrier_amplitude), 32'h3);
    cmp(32'(card_carrier_force_max), 32'h1);
    cmp(32'(shaping_bypass), 32'h1);
    cmp(32'(rise_edge_tau), 32'h0);
    cmp(32'(fall_edge_tau), 32'h5);
    cmp(32'(residual_carrier), 32'h15);
    $display("test transmit done");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_load();
    t_loop();
    t_tx();
    conclude();
  end
endmodule
